// [src/wake_defines.svh]
// constants for the standby wake-up request block
// assumes a 32-bit plain register port; included by bare name
`ifndef WAKE_DEFINES_SVH
`define WAKE_DEFINES_SVH
`define ADDR_W 4
`define OFS_SENSE 4'h0
`define OFS_CLEAR 4'h4
`define OFS_STATUS 4'h8
`define OFS_MASK 4'hC
`define EN0_BIT 0
`define ST0_LSB 2
`define CG0_LSB 4
`define EN1_BIT 8
`define ST1_LSB 10
`define CG1_LSB 12
`define SENSE_LOW 3'h0
`define SENSE_HIGH 3'h1
`define SENSE_FALL 3'h2
`define SENSE_RISE 3'h3
`define SENSE_BOTH 3'h4
`define SEEN_NONE 2'h0
`define SEEN_RISE 2'h1
`define SEEN_FALL 2'h2
`define SEEN_BOTH 2'h3
`endif

// [src/wake_pkg.sv]
// types for the standby wake-up request block
// assumes wake_defines.svh holds the numeric constants
package wake_pkg;
	typedef logic [2:0] sense_t;
	typedef logic [1:0] seen_t;
	typedef logic [31:0] word_t;
endpackage

// [src/wake_chan_if.sv]
// per-pin carrier between the top and each wake detector
// assumes one clock domain
`timescale 1ns/1ps
interface wake_chan_if;
	import wake_pkg::*;
	logic pin;
	logic enable;
	sense_t sense;
	logic clear_seen;
	logic req;
	seen_t seen;
	logic event_pulse;
	modport det (input pin, enable, sense, clear_seen, output req, seen, event_pulse);
	modport top (output pin, enable, sense, clear_seen, input req, seen, event_pulse);
endinterface

// [src/wake_detect.sv]
// one wake pin: synchroniser, sense decode and edge report
// assumes pin is gated by the top for stop-mode drive control
`timescale 1ns/1ps
`include "wake_defines.svh"
module wake_detect (
	input wire logic clk_sys, // system clock
	input wire logic reset, // sync reset, high
	wake_chan_if.det ch // per-pin channel
);
	import wake_pkg::*;
	logic sync1_ff, sync2_ff, prev_ff;
	logic rise, fall, hit;
	seen_t seen_ff;
	// two-stage synchroniser plus a history stage for edges
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			sync1_ff <= 1'h0;
			sync2_ff <= 1'h0;
			prev_ff <= 1'h0;
		end else begin
			sync1_ff <= ch.pin;
			sync2_ff <= sync1_ff;
			prev_ff <= sync2_ff;
		end
	end
	assign rise = sync2_ff & ~prev_ff;
	assign fall = ~sync2_ff & prev_ff;
	// illegal codes never match, so they raise nothing
	always_comb begin
		unique case (ch.sense)
			`SENSE_LOW: hit = ~sync2_ff;
			`SENSE_HIGH: hit = sync2_ff;
			`SENSE_FALL: hit = fall;
			`SENSE_RISE: hit = rise;
			`SENSE_BOTH: hit = rise | fall;
			default: hit = 1'h0;
		endcase
	end
	assign ch.req = ch.enable & hit;
	assign ch.event_pulse = ch.req;
	// report accumulates edges only in both-edge mode; new edge beats clear
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			seen_ff <= `SEEN_NONE;
		end else if (ch.enable && ch.sense == `SENSE_BOTH && (rise || fall)) begin
			seen_ff <= (ch.clear_seen ? `SEEN_NONE : seen_ff) | (rise ? `SEEN_RISE : `SEEN_FALL);
		end else if (ch.clear_seen) begin
			seen_ff <= `SEEN_NONE;
		end
	end
	assign ch.seen = seen_ff;
	rise_seen_a: assert property (@(posedge clk_sys) disable iff (reset)
		ch.enable && ch.sense == `SENSE_BOTH && rise |=> seen_ff[0]) else $error("rise not reported");
	clear_seen_a: assert property (@(posedge clk_sys) disable iff (reset)
		ch.clear_seen && !rise && !fall |=> seen_ff == `SEEN_NONE) else $error("report not cleared");
	only_both_a: assert property (@(posedge clk_sys) disable iff (reset)
		ch.sense != `SENSE_BOTH && !ch.clear_seen |=> $stable(seen_ff)) else $error("report moved");
	illegal_a: assert property (@(posedge clk_sys) disable iff (reset)
		ch.sense > `SENSE_BOTH |-> !ch.req) else $error("illegal code requested");
	sync_lat_a: assert property (@(posedge clk_sys) disable iff (reset)
		(ch.enable && ch.sense == `SENSE_HIGH && ch.pin) [*3] |-> ch.req)
		else $error("high level not requested after two cycles");
	both_cv: cover property (@(posedge clk_sys) disable iff (reset) seen_ff == `SEEN_BOTH);
	low_cv: cover property (@(posedge clk_sys) disable iff (reset) ch.req && ch.sense == `SENSE_LOW);
endmodule

// [src/wake_ctrl.sv]
// standby wake-up request configuration with register port and interrupt
// assumes a single-cycle strobe master; stop_mode/stop_pin_drive from mode controller
`timescale 1ns/1ps
`include "wake_defines.svh"
module wake_ctrl (
	input wire logic clk_sys, // system clock, 200 MHz
	input wire logic reset, // sync reset, high
	input wire logic [`ADDR_W-1:0] reg_addr, // byte address
	input wire wake_pkg::word_t reg_wdata, // write data
	input wire logic reg_wr, // write strobe
	input wire logic reg_rd, // read strobe
	output wake_pkg::word_t reg_rdata, // read data, cycle after strobe
	input wire logic wake_pin_0, // external wake pin 0
	input wire logic wake_pin_1, // external wake pin 1
	input wire logic stop_mode, // device is in stop mode
	input wire logic stop_pin_drive, // pin input kept alive in stop
	output logic standby_release_req, // release request to mode controller
	output logic irq // level interrupt
);
	import wake_pkg::*;
	wake_chan_if ch0 ();
	wake_chan_if ch1 ();
	sense_t sense0_ff, sense1_ff;
	logic en0_ff, en1_ff;
	logic [1:0] status_ff, mask_ff;
	word_t rdata_ff, ctrl_word;
	logic wr_sense, wr_clear, wr_status, wr_mask;
	logic [1:0] clr;
	assign wr_sense = reg_wr && reg_addr == `OFS_SENSE;
	assign wr_clear = reg_wr && reg_addr == `OFS_CLEAR;
	assign wr_status = reg_wr && reg_addr == `OFS_STATUS;
	assign wr_mask = reg_wr && reg_addr == `OFS_MASK;
	assign clr = wr_clear ? reg_wdata[1:0] : 2'h0;
	// sense and enable fields; software orders them itself
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			sense0_ff <= `SENSE_LOW;
			sense1_ff <= `SENSE_LOW;
			en0_ff <= 1'h0;
			en1_ff <= 1'h0;
		end else if (wr_sense) begin
			sense0_ff <= reg_wdata[`CG0_LSB +: 3];
			sense1_ff <= reg_wdata[`CG1_LSB +: 3];
			en0_ff <= reg_wdata[`EN0_BIT];
			en1_ff <= reg_wdata[`EN1_BIT];
		end
	end
	// in stop mode the pin reads low unless drive control keeps input alive
	assign ch0.pin = wake_pin_0 & (~stop_mode | stop_pin_drive);
	assign ch1.pin = wake_pin_1 & (~stop_mode | stop_pin_drive);
	assign ch0.enable = en0_ff;
	assign ch1.enable = en1_ff;
	assign ch0.sense = sense0_ff;
	assign ch1.sense = sense1_ff;
	assign ch0.clear_seen = clr[0];
	assign ch1.clear_seen = clr[1];
	wake_detect det0 (.clk_sys(clk_sys), .reset(reset), .ch(ch0));
	wake_detect det1 (.clk_sys(clk_sys), .reset(reset), .ch(ch1));
	assign standby_release_req = ch0.req | ch1.req;
	// sticky pending; a new event wins over a write-one clear
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			status_ff <= 2'h0;
		end else begin
			status_ff <= (status_ff & ~((wr_status ? reg_wdata[1:0] : 2'h0) | clr))
				| {ch1.event_pulse, ch0.event_pulse};
		end
	end
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			mask_ff <= 2'h0;
		end else if (wr_mask) begin
			mask_ff <= reg_wdata[1:0];
		end
	end
	assign irq = |(status_ff & mask_ff);
	// reserved and undefined bits read as zero
	always_comb begin
		ctrl_word = '0;
		ctrl_word[`EN0_BIT] = en0_ff;
		ctrl_word[`ST0_LSB +: 2] = ch0.seen;
		ctrl_word[`CG0_LSB +: 3] = sense0_ff;
		ctrl_word[`EN1_BIT] = en1_ff;
		ctrl_word[`ST1_LSB +: 2] = ch1.seen;
		ctrl_word[`CG1_LSB +: 3] = sense1_ff;
	end
	// read data stands only the cycle after the strobe; unmapped reads zero
	always_ff @(posedge clk_sys) begin
		if (reset || !reg_rd) begin
			rdata_ff <= '0;
		end else begin
			unique case (reg_addr)
				`OFS_SENSE: rdata_ff <= ctrl_word;
				`OFS_STATUS: rdata_ff <= {30'h0, status_ff};
				`OFS_MASK: rdata_ff <= {30'h0, mask_ff};
				default: rdata_ff <= '0;
			endcase
		end
	end
	assign reg_rdata = rdata_ff;
	stop_gate_a: assert property (@(posedge clk_sys) disable iff (reset)
		stop_mode && !stop_pin_drive |-> ch0.pin == 1'h0 && ch1.pin == 1'h0) else $error("pin not gated in stop");
	enable_gate_a: assert property (@(posedge clk_sys) disable iff (reset)
		!en0_ff && !en1_ff |-> !standby_release_req) else $error("request while disabled");
	sense_write_a: assert property (@(posedge clk_sys) disable iff (reset)
		wr_sense |=> sense1_ff == $past(reg_wdata[`CG1_LSB +: 3]) && en1_ff == $past(reg_wdata[`EN1_BIT]))
		else $error("sense write lost");
	sticky_a: assert property (@(posedge clk_sys) disable iff (reset)
		ch0.event_pulse |=> status_ff[0] [*1]) else $error("event not latched");
	// the clear register must drop the pending bit when no new event races it
	clear_pend_a: assert property (@(posedge clk_sys) disable iff (reset)
		wr_clear && reg_wdata[0] && !ch0.event_pulse |=> !status_ff[0]) else $error("pending not cleared");
	// read data is zero outside the cycle after a read strobe
	rdata_idle_a: assert property (@(posedge clk_sys) disable iff (reset)
		!reg_rd |=> reg_rdata == '0) else $error("read data outside its cycle");
	rel_cv: cover property (@(posedge clk_sys) disable iff (reset) standby_release_req && stop_mode);
	irq_cv: cover property (@(posedge clk_sys) disable iff (reset) irq ##1 !irq);
endmodule

// [verif/wake_pins_model.sv]
// far-side model: the two external wake pins
// assumes the bench sets lvl; pins move one rising edge later
`timescale 1ns/1ps
module wake_pins_model (
	input wire logic clk_sys, // system clock
	input wire logic [1:0] lvl, // wanted pin levels
	output logic wake_pin_0, // wake pin 0
	output logic wake_pin_1 // wake pin 1
);
	// pins follow the wanted levels one cycle late, like a slow external source
	always @(posedge clk_sys) begin
		{wake_pin_1, wake_pin_0} <= lvl;
	end
endmodule

// [verif/test_standby_wakeup_request_config.sv]
// bench for wake_ctrl: register port, sense modes, edge report, irq, stop gating
// assumes a 200 MHz clock and sync active-high reset
`timescale 1ns/1ps
`include "wake_defines.svh"
module test_standby_wakeup_request_config;
	import wake_pkg::*;
	logic clk_sys = 1'b0;
	logic reset = 1'b1;
	logic [`ADDR_W-1:0] reg_addr = '0;
	word_t reg_wdata = '0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic stop_mode = 1'b0;
	logic stop_pin_drive = 1'b0;
	logic [1:0] lvl = 2'h0;
	word_t reg_rdata, d;
	logic wake_pin_0, wake_pin_1, standby_release_req, irq;
	int failures = 0;
	int checks_done = 0;
	int n;
	// clock
	always #2.5 clk_sys = ~clk_sys;
	wake_pins_model u_pins (.clk_sys(clk_sys), .lvl(lvl), .wake_pin_0(wake_pin_0), .wake_pin_1(wake_pin_1));
	wake_ctrl u_dut (.clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .wake_pin_0(wake_pin_0),
		.wake_pin_1(wake_pin_1), .stop_mode(stop_mode), .stop_pin_drive(stop_pin_drive),
		.standby_release_req(standby_release_req), .irq(irq));
	task chk(input word_t got, input word_t exp);
		checks_done++;
		if (got !== exp) begin
			failures++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task wr(input logic [3:0] a, input word_t v);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask
	// read data stands only in the cycle after the strobe
	task rd(input logic [3:0] a);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask
	// count request-high cycles over k cycles
	task watch(input int k);
		n = 0;
		repeat (k) begin
			@(posedge clk_sys);
			#1 if (standby_release_req === 1'b1) n++;
		end
	endtask
	task pins(input logic [1:0] v);
		@(posedge clk_sys);
		lvl <= v;
	endtask
	task test_reset;
		rd(`OFS_SENSE); chk(d, 32'h0);
		rd(`OFS_STATUS); chk(d, 32'h0);
		rd(4'h2); chk(d, 32'h0);
		$display("test reset done");
	endtask
	// every sense code on pin 0, sense written before enable
	task test_modes;
		logic idle;
		for (int c = 0; c < 8; c++) begin
			idle = (c == 0 || c == 2);
			pins({1'b0, idle});
			wr(`OFS_SENSE, 32'h0);
			wr(`OFS_CLEAR, 32'h3);
			wr(`OFS_SENSE, word_t'(c) << `CG0_LSB);
			wr(`OFS_SENSE, (word_t'(c) << `CG0_LSB) | 32'h1);
			watch(4); chk(word_t'(n), 32'h0);
			pins({1'b0, ~idle});
			watch(6);
			if (c < 2) chk(standby_release_req, 1'b1);
			else chk(word_t'(n), word_t'(c < 5));
			rd(`OFS_SENSE); chk(d[`ST0_LSB +: 2], (c == 4) ? `SEEN_RISE : `SEEN_NONE);
		end
		$display("test modes done");
	endtask
	task test_both;
		pins(2'b00);
		wr(`OFS_SENSE, word_t'(`SENSE_HIGH) << `CG1_LSB);
		pins(2'b10); watch(6); chk(word_t'(n), 32'h0);
		pins(2'b00);
		wr(`OFS_SENSE, word_t'(`SENSE_BOTH) << `CG1_LSB);
		wr(`OFS_CLEAR, 32'h3);
		wr(`OFS_SENSE, (word_t'(`SENSE_BOTH) << `CG1_LSB) | (32'h1 << `EN1_BIT));
		pins(2'b10); watch(6); chk(word_t'(n), 32'h1);
		rd(`OFS_SENSE); chk(d[`ST1_LSB +: 2], `SEEN_RISE);
		pins(2'b00); watch(6);
		rd(`OFS_SENSE); chk(d[`ST1_LSB +: 2], `SEEN_BOTH);
		rd(`OFS_STATUS); chk(d[1], 1'b1);
		wr(`OFS_CLEAR, 32'h2);
		rd(`OFS_SENSE); chk(d[`ST1_LSB +: 2], `SEEN_NONE);
		rd(`OFS_STATUS); chk(d[1], 1'b0);
		$display("test both edges done");
	endtask
	task test_irq;
		pins(2'b00);
		wr(`OFS_SENSE, 32'h0);
		wr(`OFS_STATUS, 32'h3);
		wr(`OFS_MASK, 32'h0);
		wr(`OFS_SENSE, word_t'(`SENSE_RISE) << `CG0_LSB);
		wr(`OFS_SENSE, (word_t'(`SENSE_RISE) << `CG0_LSB) | 32'h1);
		pins(2'b01); watch(6);
		rd(`OFS_STATUS); chk(d, 32'h1);
		chk(irq, 1'b0);
		wr(`OFS_MASK, 32'h1); #1 chk(irq, 1'b1);
		rd(`OFS_MASK); chk(d, 32'h1);
		rd(`OFS_CLEAR); chk(d, 32'h0);
		wr(`OFS_STATUS, 32'h1); #1 chk(irq, 1'b0);
		$display("test irq done");
	endtask
	// stop mode with pin drive off hides the pin
	task test_stop;
		wr(`OFS_SENSE, word_t'(`SENSE_HIGH) << `CG0_LSB);
		wr(`OFS_SENSE, (word_t'(`SENSE_HIGH) << `CG0_LSB) | 32'h1);
		@(posedge clk_sys);
		stop_mode <= 1'b1;
		watch(6); chk(standby_release_req, 1'b0);
		@(posedge clk_sys);
		stop_pin_drive <= 1'b1;
		watch(6); chk(standby_release_req, 1'b1);
		$display("test stop done");
	endtask
	task end_sim;
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	// main sequence
	initial begin
		repeat (12) @(posedge clk_sys);
		reset <= 1'b0;
		test_reset;
		test_modes;
		test_both;
		test_irq;
		test_stop;
		end_sim;
	end
	// watchdog, far beyond the expected run
	initial begin
		#40000;
		failures++;
		end_sim;
	end
endmodule
